// ---- bfb_pkg.sv ----
// Shared constants and types for the bidirectional FIFO host controller.
package bfb_pkg;

    // ==========================================================
    // Widths and buffer shape
    // ==========================================================
    localparam int DATA_W = 9;
    localparam int BUF_DEPTH = 8;
    localparam int CNT_W = 3;

    // ==========================================================
    // Timing, in nanoseconds and derived core clock cycles
    // ==========================================================
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_PULSE_NS = 65;
    localparam int T_RECOVER_NS = 15;
    localparam int PULSE_RAW = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_RAW = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
    localparam int RECOVER_CYC = (RECOVER_RAW < 1) ? 1 : RECOVER_RAW;

    // ==========================================================
    // Port indices and fill-level codes
    // ==========================================================
    localparam logic PORT_A = 1'b0;
    localparam logic PORT_B = 1'b1;
    localparam logic [1:0] FILL_EMPTY = 2'h0;
    localparam logic [1:0] FILL_BELOW_HALF = 2'h1;
    localparam logic [1:0] FILL_HALF = 2'h2;
    localparam logic [1:0] FILL_FULL = 2'h3;
    localparam logic DIR_A_WRITES_RST = 1'b1;

    typedef enum logic [2:0] {
        OP_DIR_SET,
        OP_FIFO_WRITE,
        OP_FIFO_READ,
        OP_BYP_WRITE,
        OP_BYP_READ,
        OP_TRANSPARENT
    } bfb_op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CLEAR,
        ST_CLR_HOLD,
        ST_ACTIVE,
        ST_RECOVER
    } bfb_state_t;

endpackage

// ---- bfb_buf_if.sv ----
// Carrier for the drain side of the outgoing word buffer.
`timescale 1ns/1ns
interface bfb_buf_if;
    logic valid;
    logic ready;
    logic [bfb_pkg::DATA_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- bfb_fifo.sv ----
// Small synchronous FIFO that holds words waiting to be written to the device.
`timescale 1ns/1ns
module bfb_fifo #(
    parameter int WIDTH = bfb_pkg::DATA_W,
    parameter int DEPTH = bfb_pkg::BUF_DEPTH
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    bfb_buf_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // ==========================================================
    // Handshake
    // ==========================================================
    assign wr_ready = (count_ff != (AW+1)'(DEPTH));
    assign rd.valid = (count_ff != '0);
    assign rd.data = mem[rd_ptr_ff];
    assign push = wr_valid && wr_ready;
    assign pop = rd.valid && rd.ready;

    // ==========================================================
    // Storage and pointers
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- bfb_host.sv ----
// Host controller that drives both data ports of a bidirectional FIFO device.
`timescale 1ns/1ns
module bfb_host (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic buf_in_valid,
    output logic buf_in_ready,
    input wire logic [bfb_pkg::DATA_W-1:0] buf_in_data,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire bfb_pkg::bfb_op_t cmd_op,
    input wire logic cmd_port,
    input wire logic [bfb_pkg::DATA_W-1:0] cmd_data,
    output logic rsp_valid,
    output logic rsp_err,
    output logic [bfb_pkg::DATA_W-1:0] rsp_data,
    output logic dir_a_writes,
    output logic [1:0] fill_state,
    output logic master_clear_n,
    output logic port_a_strobe_n,
    output logic port_b_strobe_n,
    output logic port_a_bypass_sel_n,
    output logic port_b_bypass_sel_n,
    input wire logic empty_full_n,
    input wire logic half_level_flag_n,
    input wire logic bypass_word_avail_n,
    input wire logic [bfb_pkg::DATA_W-1:0] port_a_data_in,
    output logic [bfb_pkg::DATA_W-1:0] port_a_data_out,
    output logic port_a_data_oe_n,
    input wire logic [bfb_pkg::DATA_W-1:0] port_b_data_in,
    output logic [bfb_pkg::DATA_W-1:0] port_b_data_out,
    output logic port_b_data_oe_n
);
    bfb_pkg::bfb_state_t state_ff;
    bfb_pkg::bfb_op_t op_ff;
    logic [bfb_pkg::CNT_W-1:0] cnt_ff;
    logic [1:0] stb_n_ff;
    logic [1:0] byp_n_ff;
    logic [1:0] oe_n_ff;
    logic [bfb_pkg::DATA_W-1:0] dout_ff;
    logic [bfb_pkg::DATA_W-1:0] rsp_data_ff;
    logic mclr_n_ff;
    logic dir_ff;
    logic new_dir_ff;
    logic rx_port_ff;
    logic rsp_valid_ff;
    logic rsp_err_ff;

    bfb_buf_if bif();

    bfb_fifo #(
        .WIDTH(bfb_pkg::DATA_W),
        .DEPTH(bfb_pkg::BUF_DEPTH)
    ) u_buf (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr_valid(buf_in_valid),
        .wr_ready(buf_in_ready),
        .wr_data(buf_in_data),
        .rd(bif.src)
    );

    // ==========================================================
    // Flag decoding and command steering
    // ==========================================================
    wire [1:0] fill_dec = {~half_level_flag_n, ~empty_full_n ^ half_level_flag_n};
    wire is_full = (fill_dec == bfb_pkg::FILL_FULL);
    wire is_empty = (fill_dec == bfb_pkg::FILL_EMPTY);
    wire byp_avail = ~bypass_word_avail_n;
    wire writer = dir_ff ? bfb_pkg::PORT_A : bfb_pkg::PORT_B;
    wire is_fw = (cmd_op == bfb_pkg::OP_FIFO_WRITE);
    wire is_fr = (cmd_op == bfb_pkg::OP_FIFO_READ);
    wire is_bw = (cmd_op == bfb_pkg::OP_BYP_WRITE);
    wire is_br = (cmd_op == bfb_pkg::OP_BYP_READ);
    wire is_tr = (cmd_op == bfb_pkg::OP_TRANSPARENT);
    wire is_ds = (cmd_op == bfb_pkg::OP_DIR_SET);
    // A full bypass register is not overwritten, and a read of an empty one is refused.
    wire refused = (is_fw && is_full) || (is_fr && is_empty) ||
                   (is_bw && byp_avail) || (is_br && !byp_avail);
    // The bypass register is loaded from the FIFO read side and drained at the write side.
    wire act_port = is_tr ? cmd_port : ((is_fw || is_br) ? writer : ~writer);
    wire rx_port = is_tr ? ~cmd_port : act_port;
    wire drives = is_fw || is_bw || is_tr;
    wire use_stb = is_fw || is_fr || is_tr;
    wire use_byp = is_bw || is_br || is_tr;
    wire idle = (state_ff == bfb_pkg::ST_IDLE);
    wire accept = idle && cmd_valid && cmd_ready;
    wire [1:0] sel = act_port ? 2'b10 : 2'b01;
    wire [bfb_pkg::DATA_W-1:0] rx_data = rx_port_ff ? port_b_data_in : port_a_data_in;

    assign fill_state = fill_dec;
    assign cmd_ready = idle && (!is_fw || bif.valid || refused);
    assign bif.ready = idle && cmd_valid && is_fw && !refused;

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= bfb_pkg::ST_IDLE;
            op_ff <= bfb_pkg::OP_DIR_SET;
            cnt_ff <= '0;
            stb_n_ff <= 2'b11;
            byp_n_ff <= 2'b11;
            oe_n_ff <= 2'b11;
            dout_ff <= '0;
            rsp_data_ff <= '0;
            mclr_n_ff <= 1'b1;
            dir_ff <= bfb_pkg::DIR_A_WRITES_RST;
            new_dir_ff <= bfb_pkg::DIR_A_WRITES_RST;
            rx_port_ff <= bfb_pkg::PORT_A;
            rsp_valid_ff <= 1'b0;
            rsp_err_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= 1'b0;
            case (state_ff)
                bfb_pkg::ST_IDLE: begin
                    if (accept && refused) begin
                        rsp_valid_ff <= 1'b1;
                        rsp_err_ff <= 1'b1;
                    end else if (accept && is_ds) begin
                        // Direction level goes out with the clear so it is settled well ahead.
                        op_ff <= cmd_op;
                        new_dir_ff <= cmd_data[0];
                        byp_n_ff <= {1'b1, cmd_data[0]};
                        mclr_n_ff <= 1'b0;
                        cnt_ff <= bfb_pkg::CNT_W'(bfb_pkg::PULSE_CYC - 1);
                        state_ff <= bfb_pkg::ST_CLEAR;
                    end else if (accept) begin
                        op_ff <= cmd_op;
                        rx_port_ff <= rx_port;
                        dout_ff <= is_fw ? bif.data : cmd_data;
                        stb_n_ff <= use_stb ? ~sel : 2'b11;
                        byp_n_ff <= use_byp ? ~sel : 2'b11;
                        oe_n_ff <= drives ? ~sel : 2'b11;
                        cnt_ff <= bfb_pkg::CNT_W'(bfb_pkg::PULSE_CYC - 1);
                        state_ff <= bfb_pkg::ST_ACTIVE;
                    end
                end
                bfb_pkg::ST_CLEAR: begin
                    if (cnt_ff == '0) begin
                        mclr_n_ff <= 1'b1;
                        dir_ff <= new_dir_ff;
                        state_ff <= bfb_pkg::ST_CLR_HOLD;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                bfb_pkg::ST_CLR_HOLD: begin
                    byp_n_ff <= 2'b11;
                    cnt_ff <= bfb_pkg::CNT_W'(bfb_pkg::RECOVER_CYC - 1);
                    state_ff <= bfb_pkg::ST_RECOVER;
                end
                bfb_pkg::ST_ACTIVE: begin
                    if (cnt_ff == '0) begin
                        rsp_data_ff <= rx_data;
                        stb_n_ff <= 2'b11;
                        byp_n_ff <= 2'b11;
                        cnt_ff <= bfb_pkg::CNT_W'(bfb_pkg::RECOVER_CYC - 1);
                        state_ff <= bfb_pkg::ST_RECOVER;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                bfb_pkg::ST_RECOVER: begin
                    // Driven data outlives the strobe by a cycle to cover the device hold time.
                    oe_n_ff <= 2'b11;
                    if (cnt_ff == '0) begin
                        rsp_valid_ff <= 1'b1;
                        rsp_err_ff <= 1'b0;
                        state_ff <= bfb_pkg::ST_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= bfb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp_err = rsp_err_ff;
    assign rsp_data = rsp_data_ff;
    assign dir_a_writes = dir_ff;
    assign master_clear_n = mclr_n_ff;
    assign port_a_strobe_n = stb_n_ff[0];
    assign port_b_strobe_n = stb_n_ff[1];
    assign port_a_bypass_sel_n = byp_n_ff[0];
    assign port_b_bypass_sel_n = byp_n_ff[1];
    assign port_a_data_oe_n = oe_n_ff[0];
    assign port_b_data_oe_n = oe_n_ff[1];
    assign port_a_data_out = dout_ff;
    assign port_b_data_out = dout_ff;

    // ==========================================================
    // Checks on the pin sequences this controller produces
    // ==========================================================
    a_clear_dir_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(master_clear_n) |-> $stable(port_a_bypass_sel_n))
        else $error("A bypass changed at clear release");

    a_dir_adopted: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(master_clear_n) |-> dir_a_writes == port_a_bypass_sel_n)
        else $error("Direction does not match bypass level at clear release");

    a_write_drives: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_ff == bfb_pkg::ST_ACTIVE && op_ff == bfb_pkg::OP_FIFO_WRITE)
        |-> (dir_a_writes ? (!port_a_strobe_n && !port_a_data_oe_n && port_b_strobe_n)
                          : (!port_b_strobe_n && !port_b_data_oe_n && port_a_strobe_n)))
        else $error("FIFO write not on the writer port with data driven");

    a_read_floats: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_ff == bfb_pkg::ST_ACTIVE && op_ff == bfb_pkg::OP_FIFO_READ)
        |-> port_a_data_oe_n && port_b_data_oe_n
            && (dir_a_writes ? !port_b_strobe_n : !port_a_strobe_n))
        else $error("FIFO read strobe wrong or host still driving");

    a_fifo_byp_high: assert property (@(posedge core_clk) disable iff (!resetn)
        (!port_a_strobe_n || !port_b_strobe_n) && op_ff != bfb_pkg::OP_TRANSPARENT
        |-> port_a_bypass_sel_n && port_b_bypass_sel_n)
        else $error("Bypass select low during a FIFO transfer");

    a_byp_strobe_high: assert property (@(posedge core_clk) disable iff (!resetn)
        (!port_a_bypass_sel_n || !port_b_bypass_sel_n) && op_ff != bfb_pkg::OP_TRANSPARENT
        |-> port_a_strobe_n && port_b_strobe_n)
        else $error("Strobe low during a registered bypass transfer");

    a_byp_read_gate: assert property (@(posedge core_clk) disable iff (!resetn)
        accept && is_br && !refused |-> !bypass_word_avail_n
        ##1 (dir_a_writes ? !port_a_bypass_sel_n : !port_b_bypass_sel_n))
        else $error("Bypass read issued without data available");

    a_trans_together: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(port_a_strobe_n) && op_ff == bfb_pkg::OP_TRANSPARENT
        |-> $fell(port_a_bypass_sel_n) && !port_a_data_oe_n && port_b_data_oe_n)
        else $error("Transparent send without bypass and strobe falling together");

    a_byp_write_port: assert property (@(posedge core_clk) disable iff (!resetn)
        accept && is_bw && !refused
        |=> (dir_a_writes ? (!port_b_bypass_sel_n && !port_b_data_oe_n)
                          : (!port_a_bypass_sel_n && !port_a_data_oe_n)))
        else $error("Bypass load not on the FIFO read port");
endmodule

// ---- bfb_dev_model.sv ----
// Behavioural model of the bidirectional FIFO device that the host drives.
`timescale 1ns/1ns
module bfb_dev_model #(
    parameter int DEPTH = 2048
) (
    input wire logic master_clear_n,
    input wire logic port_a_strobe_n,
    input wire logic port_b_strobe_n,
    input wire logic port_a_bypass_sel_n,
    input wire logic port_b_bypass_sel_n,
    input wire logic [8:0] port_a_host_out,
    input wire logic port_a_host_oe_n,
    input wire logic [8:0] port_b_host_out,
    input wire logic port_b_host_oe_n,
    output logic empty_full_n,
    output logic half_level_flag_n,
    output logic bypass_word_avail_n,
    output logic [8:0] port_a_level,
    output logic [8:0] port_b_level
);
    // ==========================================================
    // Storage and state, all reached through pins only
    // ==========================================================
    logic [8:0] mem [DEPTH];
    logic [8:0] byp_word = 9'h0_00;
    logic [8:0] float_pat = 9'h0_a5;
    logic a_writes = 1'h1;
    logic byp_full = 1'h0;
    logic a_sok = 1'h0;
    logic b_sok = 1'h0;
    logic a_bok = 1'h0;
    logic b_bok = 1'h0;
    int wr_ptr = 0;
    int rd_ptr = 0;
    int count = 0;
    logic a_tr, b_tr, conflict, a_en, b_en;

    // A released pin shows a changing pattern, so stale data can never pass for a read.
    always #50 float_pat = ~float_pat;

    // ==========================================================
    // Pin drive
    // ==========================================================
    assign a_tr = !port_a_strobe_n && !port_a_bypass_sel_n;
    assign b_tr = !port_b_strobe_n && !port_b_bypass_sel_n;
    assign conflict = (a_tr && (!port_b_strobe_n || !port_b_bypass_sel_n))
        || (b_tr && (!port_a_strobe_n || !port_a_bypass_sel_n))
        || (!port_a_bypass_sel_n && !port_b_bypass_sel_n);
    assign a_en = !conflict && (b_tr || (a_writes ? (!port_a_bypass_sel_n && port_a_strobe_n)
        : (!port_a_strobe_n && port_a_bypass_sel_n)));
    assign b_en = !conflict && (a_tr || (!a_writes ? (!port_b_bypass_sel_n && port_b_strobe_n)
        : (!port_b_strobe_n && port_b_bypass_sel_n)));
    assign port_a_level = !port_a_host_oe_n ? port_a_host_out : !a_en ? float_pat
        : b_tr ? port_b_level : a_writes ? byp_word : mem[rd_ptr];
    assign port_b_level = !port_b_host_oe_n ? port_b_host_out : !b_en ? float_pat
        : a_tr ? port_a_level : !a_writes ? byp_word : mem[rd_ptr];

    // ==========================================================
    // Flags
    // ==========================================================
    assign empty_full_n = !(count == 0 || count == DEPTH);
    assign half_level_flag_n = !(count >= DEPTH / 2);
    assign bypass_word_avail_n = !byp_full;

    // ==========================================================
    // Strobe and bypass events
    // ==========================================================
    task automatic strobe_done(input logic on_a, input logic [8:0] lvl);
        if (on_a == a_writes) begin
            if (count < DEPTH) begin
                mem[wr_ptr] = lvl;
                wr_ptr = (wr_ptr + 1) % DEPTH;
                count++;
            end
        end else if (count > 0) begin
            rd_ptr = (rd_ptr + 1) % DEPTH;
            count--;
        end
    endtask

    // Test mode, loading and reading back at one port, has no pin sequence from this host.
    // The model therefore never enters it and keeps the two ports apart.

    // The bypass path never moves a pointer or the count.
    task automatic bypass_done(input logic on_a, input logic [8:0] lvl);
        if (on_a == a_writes) begin
            byp_full = 1'h0;
        end else begin
            byp_word = lvl;
            byp_full = 1'h1;
        end
    endtask

    // The kind of transfer is judged 2 ns after a fall, once both selects have settled.
    always @(negedge port_a_strobe_n) #2 a_sok = port_a_bypass_sel_n && master_clear_n;
    always @(negedge port_b_strobe_n) #2 b_sok = port_b_bypass_sel_n && master_clear_n;
    always @(negedge port_a_bypass_sel_n) #2 a_bok = port_a_strobe_n && master_clear_n;
    always @(negedge port_b_bypass_sel_n) #2 b_bok = port_b_strobe_n && master_clear_n;
    always @(posedge port_a_strobe_n) if (a_sok) strobe_done(1'h1, port_a_level);
    always @(posedge port_b_strobe_n) if (b_sok) strobe_done(1'h0, port_b_level);
    always @(posedge port_a_bypass_sel_n) if (a_bok) bypass_done(1'h1, port_a_level);
    always @(posedge port_b_bypass_sel_n) if (b_bok) bypass_done(1'h0, port_b_level);

    always @(negedge master_clear_n) begin
        wr_ptr = 0;
        rd_ptr = 0;
        count = 0;
        byp_full = 1'h0;
    end
    always @(posedge master_clear_n) a_writes = port_a_bypass_sel_n;
endmodule

// ---- bfb_host_tb_top.sv ----
// Self-checking bench for the bidirectional FIFO host controller.
`timescale 1ns/1ns
module bfb_host_tb_top;
    typedef struct {
        bfb_pkg::bfb_op_t op;
        logic port;
        logic [8:0] data;
        logic err;
        logic chk;
        logic [8:0] rdata;
        logic [1:0] fill;
        logic dir;
    } bfb_row_t;
    localparam bfb_pkg::bfb_op_t K_DIR = bfb_pkg::OP_DIR_SET;
    localparam bfb_pkg::bfb_op_t K_WR = bfb_pkg::OP_FIFO_WRITE;
    localparam bfb_pkg::bfb_op_t K_RD = bfb_pkg::OP_FIFO_READ;
    localparam bfb_pkg::bfb_op_t K_BW = bfb_pkg::OP_BYP_WRITE;
    localparam bfb_pkg::bfb_op_t K_BR = bfb_pkg::OP_BYP_READ;
    localparam bfb_pkg::bfb_op_t K_TR = bfb_pkg::OP_TRANSPARENT;
    logic core_clk, resetn, buf_in_valid, cmd_valid, cmd_port;
    logic [8:0] buf_in_data, cmd_data, rsp_data, port_a_data_out, port_b_data_out;
    logic [8:0] port_a_level, port_b_level;
    bfb_pkg::bfb_op_t cmd_op;
    logic buf_in_ready, cmd_ready, rsp_valid, rsp_err, dir_a_writes, master_clear_n;
    logic port_a_strobe_n, port_b_strobe_n, port_a_bypass_sel_n, port_b_bypass_sel_n;
    logic empty_full_n, half_level_flag_n, bypass_word_avail_n;
    logic port_a_data_oe_n, port_b_data_oe_n;
    logic [1:0] fill_state;
    wire [8:0] idle_pins = {master_clear_n, port_a_strobe_n, port_b_strobe_n, port_a_bypass_sel_n,
        port_b_bypass_sel_n, port_a_data_oe_n, port_b_data_oe_n, dir_a_writes, rsp_valid};
    int err_total = 0;
    int compares = 0;
    bfb_row_t rows [20];

    bfb_host i_bfb_host (.core_clk, .resetn, .buf_in_valid, .buf_in_ready, .buf_in_data,
        .cmd_valid, .cmd_ready, .cmd_op, .cmd_port, .cmd_data, .rsp_valid, .rsp_err,
        .rsp_data, .dir_a_writes, .fill_state, .master_clear_n, .port_a_strobe_n,
        .port_b_strobe_n, .port_a_bypass_sel_n, .port_b_bypass_sel_n, .empty_full_n,
        .half_level_flag_n, .bypass_word_avail_n, .port_a_data_in(port_a_level),
        .port_a_data_out, .port_a_data_oe_n, .port_b_data_in(port_b_level),
        .port_b_data_out, .port_b_data_oe_n);

    // A small depth lets the full and half-full levels be reached in a short run.
    bfb_dev_model #(.DEPTH(8)) i_bfb_dev_model (.master_clear_n, .port_a_strobe_n,
        .port_b_strobe_n, .port_a_bypass_sel_n, .port_b_bypass_sel_n,
        .port_a_host_out(port_a_data_out), .port_a_host_oe_n(port_a_data_oe_n),
        .port_b_host_out(port_b_data_out), .port_b_host_oe_n(port_b_data_oe_n),
        .empty_full_n, .half_level_flag_n, .bypass_word_avail_n, .port_a_level,
        .port_b_level);

    // ==========================================================
    // Clock, checking and closing
    // ==========================================================
    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Called at a falling edge; returns at the falling edge that shows the response.
    task automatic run_cmd(input bfb_pkg::bfb_op_t op, input logic port, input logic [8:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        cmd_op = op;
        cmd_port = port;
        cmd_data = d;
        cmd_valid = 1'h1;
        // The request stands until the rising edge at which ready is seen high.
        do begin
            @(posedge core_clk);
            n++;
        end while (cmd_ready !== 1'h1 && n < 20);
        @(negedge core_clk);
        cmd_valid = 1'h0;
        n = 0;
        while (rsp_valid !== 1'h1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 20) check("rsp_valid", 9'(rsp_valid), 9'h0_01);
    endtask

    task automatic push(input logic [8:0] w);
        buf_in_data = w;
        buf_in_valid = 1'h1;
        do @(posedge core_clk); while (buf_in_ready !== 1'h1);
        @(negedge core_clk);
        buf_in_valid = 1'h0;
        @(negedge core_clk);
    endtask

    initial begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        print_verdict();
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        resetn = 1'h0;
        buf_in_valid = 1'h0;
        buf_in_data = 9'h0_00;
        cmd_valid = 1'h0;
        cmd_op = K_DIR;
        cmd_port = 1'h0;
        cmd_data = 9'h0_00;
        rows = '{
            '{K_DIR, 1'h0, 9'h0_01, 1'h0, 1'h0, 9'h0_00, 2'h0, 1'h1},
            '{K_RD, 1'h0, 9'h0_00, 1'h1, 1'h0, 9'h0_00, 2'h0, 1'h1},
            '{K_BR, 1'h0, 9'h0_00, 1'h1, 1'h0, 9'h0_00, 2'h0, 1'h1},
            '{K_WR, 1'h0, 9'h0_00, 1'h0, 1'h0, 9'h0_00, 2'h1, 1'h1},
            '{K_BW, 1'h0, 9'h1_ff, 1'h0, 1'h0, 9'h0_00, 2'h1, 1'h1},
            '{K_BW, 1'h0, 9'h0_11, 1'h1, 1'h0, 9'h0_00, 2'h1, 1'h1},
            '{K_BR, 1'h0, 9'h0_00, 1'h0, 1'h1, 9'h1_ff, 2'h1, 1'h1},
            '{K_WR, 1'h0, 9'h0_00, 1'h0, 1'h0, 9'h0_00, 2'h1, 1'h1},
            '{K_RD, 1'h0, 9'h0_00, 1'h0, 1'h1, 9'h1_23, 2'h1, 1'h1},
            '{K_RD, 1'h0, 9'h0_00, 1'h0, 1'h1, 9'h0_45, 2'h0, 1'h1},
            '{K_TR, 1'h0, 9'h0_3c, 1'h0, 1'h1, 9'h0_3c, 2'h0, 1'h1},
            '{K_TR, 1'h1, 9'h1_c3, 1'h0, 1'h1, 9'h1_c3, 2'h0, 1'h1},
            '{K_BW, 1'h0, 9'h0_55, 1'h0, 1'h0, 9'h0_00, 2'h0, 1'h1},
            '{K_DIR, 1'h0, 9'h0_00, 1'h0, 1'h0, 9'h0_00, 2'h0, 1'h0},
            '{K_BR, 1'h0, 9'h0_00, 1'h1, 1'h0, 9'h0_00, 2'h0, 1'h0},
            '{K_WR, 1'h0, 9'h0_00, 1'h0, 1'h0, 9'h0_00, 2'h1, 1'h0},
            '{K_BW, 1'h0, 9'h0_aa, 1'h0, 1'h0, 9'h0_00, 2'h1, 1'h0},
            '{K_BR, 1'h0, 9'h0_00, 1'h0, 1'h1, 9'h0_aa, 2'h1, 1'h0},
            '{K_RD, 1'h0, 9'h0_00, 1'h0, 1'h1, 9'h0_99, 2'h0, 1'h0},
            '{K_RD, 1'h0, 9'h0_00, 1'h1, 1'h0, 9'h0_00, 2'h0, 1'h0}};
        repeat (12) @(negedge core_clk);
        check("idle pins", idle_pins, 9'h1_fe);
        resetn = 1'h1;
        $display("reset test done");
        push(9'h1_23);
        push(9'h0_45);
        push(9'h0_99);
        foreach (rows[i]) begin
            run_cmd(rows[i].op, rows[i].port, rows[i].data);
            check("rsp_err", 9'(rsp_err), 9'(rows[i].err));
            if (rows[i].chk) check("rsp_data", rsp_data, rows[i].rdata);
            check("fill_state", 9'(fill_state), 9'(rows[i].fill));
            check("dir_a_writes", 9'(dir_a_writes), 9'(rows[i].dir));
        end
        $display("table test done");
        // A reset in mid-run puts the host back to A writing; the device keeps B, so set it again.
        resetn = 1'h0;
        @(negedge core_clk);
        check("reset pins", idle_pins, 9'h1_fe);
        resetn = 1'h1;
        run_cmd(K_DIR, 1'h0, 9'h0_00);
        check("dir_a_writes", 9'(dir_a_writes), 9'h0_00);
        $display("mid-run reset test done");
        for (int i = 0; i < 8; i++) push(9'(i * 37 + 5));
        check("buf_in_ready", 9'(buf_in_ready), 9'h0_00);
        for (int i = 1; i <= 8; i++) begin
            run_cmd(K_WR, 1'h0, 9'h0_00);
            check("fill_state", 9'(fill_state),
                (i == 8) ? 9'h0_03 : (i >= 4) ? 9'h0_02 : 9'h0_01);
        end
        push(9'h1_55);
        run_cmd(K_WR, 1'h0, 9'h0_00);
        check("rsp_err", 9'(rsp_err), 9'h0_01);
        for (int i = 0; i < 6; i++) begin
            run_cmd(K_RD, 1'h0, 9'h0_00);
            check("rsp_data", rsp_data, 9'(i * 37 + 5));
        end
        run_cmd(K_DIR, 1'h0, 9'h0_01);
        check("fill_state", 9'(fill_state), 9'h0_00);
        run_cmd(K_RD, 1'h0, 9'h0_00);
        check("rsp_err", 9'(rsp_err), 9'h0_01);
        run_cmd(K_WR, 1'h0, 9'h0_00);
        run_cmd(K_RD, 1'h0, 9'h0_00);
        check("rsp_data", rsp_data, 9'h1_55);
        $display("full and clear test done");
        print_verdict();
    end
endmodule
